/* pkg/bcu_pkg.sv */
// package: constants, field positions and state types of the buffered channel command unit
// Summary of operation
// - answer every instruction within four microseconds
// - reply when operation possible, else reject
// - busy rejects buffered start, direct input, output
// - protect fault on request returns reject
// - device reject on direct passes reject
// - function selector and target enable/disable interrupt
// - function with target bit clears pending interrupt
// - interrupt raised at block end when enabled
// - protected buffer rejects unprotected control instructions
// - protect fault sets status word bit
// - select field upper five, device lower eleven
// - drive zero channel-select indication to devices
// - continue flag forces direct input or output
// - four consecutive codes pick the operation
// - five-bit field: continue flag plus hex digit
// - direct input presents address, returns device word
// - terminate stops buffer, returns current address
// - status request returns operating conditions word
// - current address returned, buffer keeps running
// - buffered words moved over storage access bus
// - connect device, drive read or write strobe
// - sixteen-bit path to up to eight devices
// - word at first pointer gives block end
// - per-word strobe, device reject retries word forever
// - status bits ready busy irq eoo fault rej rep
// - busy during block transfer and direct operation
package bcu_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int ANSWER_TIME_NS = 4000;
	// longest time: rounds down
	localparam int ANSWER_CYCLES = ANSWER_TIME_NS / CLK_PERIOD_NS;
	// leave room for the answer stage around the device wait
	localparam int DEV_WAIT_CYCLES = ANSWER_CYCLES - 8;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CONT_BIT = 15;
	localparam int W_LO_MSB = 14;
	localparam int W_LO_LSB = 11;
	localparam int SEL_BIT = 15;
	localparam int TGT_BIT = 0;
	localparam int ST_READY = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_IRQ = 2;
	localparam int ST_EOO = 4;
	localparam int ST_PFAULT = 6;
	localparam int ST_DREJ = 8;
	localparam int ST_DREP = 9;
	// ****************************************************************
	// register map and reset values
	// ****************************************************************
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CUR_ADDR = 4'h4;
	localparam logic [3:0] REG_CONFIG = 4'h8;
	localparam logic [3:0] BASE_CODE_RESET = 4'h2;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] WORD_ONE = 16'h0001;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		OP_DIRECT = 2'b00,
		OP_TERM_FUNC = 2'b01,
		OP_STATUS_BOUT = 2'b10,
		OP_ADDR_BIN = 2'b11
	} bcu_op_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WAIT = 2'b01,
		H_ANS = 2'b11
	} bcu_host_state_t;
	typedef enum logic [2:0] {
		E_IDLE = 3'b000,
		E_PTR = 3'b001,
		E_MEM = 3'b011,
		E_DEV = 3'b010,
		E_GAP = 3'b110,
		E_DIR = 3'b111
	} bcu_eng_state_t;
endpackage

/* rtl/bcu_op_decode.sv */
// module: channel-select field decoder
`timescale 1ns/1ps
module bcu_op_decode (
	input wire logic [15:0] q_i,
	input wire logic [3:0] base_i,
	output logic mine_o,
	output bcu_pkg::bcu_op_t op_o
);
	wire cont_w;
	wire [3:0] w_low;
	wire [3:0] diff_w;
	wire in_range_w;
	assign cont_w = q_i[bcu_pkg::CONT_BIT];
	assign w_low = q_i[bcu_pkg::W_LO_MSB:bcu_pkg::W_LO_LSB];
	assign diff_w = w_low - base_i;
	// four consecutive codes from the configured base, none above code F
	assign in_range_w = (w_low >= base_i) && (diff_w[3:2] == 2'b00);
	assign mine_o = cont_w | in_range_w;
	// continue flag: always a direct transfer, direction from the instruction
	assign op_o = cont_w ? bcu_pkg::OP_DIRECT : bcu_pkg::bcu_op_t'(diff_w[1:0]);
endmodule

/* rtl/bcu_wb_regs.sv */
// module: classic wishbone register slave
`timescale 1ns/1ps
module bcu_wb_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [15:0] status_i,
	input wire logic [15:0] cur_addr_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [3:0] base_code_o
);
	logic [31:0] wb_dat_reg;
	logic wb_ack_reg;
	logic [3:0] base_reg;
	wire access_w;
	wire [31:0] rd_mux_w;
	assign access_w = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
	// unmapped offsets read zero and are still acknowledged
	assign rd_mux_w = (wb_adr_i == bcu_pkg::REG_STATUS) ? {16'h0000, status_i} :
		(wb_adr_i == bcu_pkg::REG_CUR_ADDR) ? {16'h0000, cur_addr_i} :
		(wb_adr_i == bcu_pkg::REG_CONFIG) ? {28'h000_0000, base_reg} : 32'h0000_0000;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h0000_0000;
			base_reg <= bcu_pkg::BASE_CODE_RESET;
		end else if (ce_i) begin
			wb_ack_reg <= access_w;
			if (access_w && !wb_we_i) begin
				wb_dat_reg <= rd_mux_w;
			end
			if (access_w && wb_we_i && wb_sel_i[0] && wb_adr_i == bcu_pkg::REG_CONFIG) begin
				base_reg <= wb_dat_i[3:0];
			end
		end
	end
	assign wb_dat_o = wb_dat_reg;
	assign wb_ack_o = wb_ack_reg;
	assign base_code_o = base_reg;
endmodule

/* rtl/bcu_channel.sv */
// module: buffered channel command unit top level
`timescale 1ns/1ps
module bcu_channel (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic host_req_i,
	input wire logic host_read_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [15:0] host_data_i,
	input wire logic host_protect_i,
	input wire logic host_pfault_i,
	output logic host_reply_o,
	output logic host_reject_o,
	output logic [15:0] host_data_o,
	output logic host_irq_o,
	output logic [15:0] dev_addr_o,
	output logic [15:0] dev_wdata_o,
	input wire logic [15:0] dev_rdata_i,
	output logic dev_rd_o,
	output logic dev_wr_o,
	input wire logic dev_reply_i,
	input wire logic dev_reject_i,
	output logic dev_wzero_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic mem_fault_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// ****************
	// state
	// ****************
	bcu_pkg::bcu_host_state_t hst_reg;
	bcu_pkg::bcu_eng_state_t est_reg;
	logic host_reply_reg, host_reject_reg, irq_en_reg, irq_pend_reg, eoo_reg, pf_reg, buf_prot_reg;
	logic buf_active_reg, buf_in_reg, dev_rd_reg, dev_wr_reg, dev_wzero_reg, mem_req_reg, mem_we_reg;
	logic last_rep_reg, last_rej_reg, done_pulse_reg, fault_pulse_reg, op_mine;
	logic [15:0] host_data_reg, cur_reg, end_reg, dev_addr_reg, dev_wdata_reg, mem_addr_reg, mem_wdata_reg;
	logic [8:0] wait_cnt_reg;
	logic [15:0] status_w;
	// ****************
	// decode and request qualification
	// ****************
	bcu_pkg::bcu_op_t op_code;
	logic [3:0] base_code;
	bcu_op_decode u_decode (
		.q_i(host_addr_i),
		.base_i(base_code),
		.mine_o(op_mine),
		.op_o(op_code)
	);
	wire new_req_w, eng_busy_w, prot_block_w, is_direct_w, is_start_w, rej_busy_w, rej_prot_w, rej_now_w;
	wire go_direct_w, go_buffer_w, do_term_w, do_func_w, dir_hit_w, out_dir_w;
	wire [15:0] ans_data_w, cur_inc_w;
	// requests for other channels are left unanswered; the host rejects them itself
	assign new_req_w = (hst_reg == bcu_pkg::H_IDLE) && host_req_i && op_mine;
	assign eng_busy_w = (est_reg != bcu_pkg::E_IDLE);
	assign prot_block_w = buf_active_reg & buf_prot_reg & ~host_protect_i;
	assign is_direct_w = (op_code == bcu_pkg::OP_DIRECT);
	assign is_start_w = !host_read_i && (op_code == bcu_pkg::OP_STATUS_BOUT || op_code == bcu_pkg::OP_ADDR_BIN);
	assign rej_busy_w = eng_busy_w && (is_direct_w || is_start_w);
	assign rej_prot_w = !is_direct_w && !is_start_w && prot_block_w;
	assign rej_now_w = host_pfault_i | rej_busy_w | rej_prot_w;
	assign go_direct_w = new_req_w & ~rej_now_w & is_direct_w;
	assign go_buffer_w = new_req_w & ~rej_now_w & is_start_w;
	assign do_term_w = new_req_w & ~rej_now_w & host_read_i & (op_code == bcu_pkg::OP_TERM_FUNC);
	assign do_func_w = new_req_w & ~rej_now_w & ~host_read_i & (op_code == bcu_pkg::OP_TERM_FUNC);
	// status code on input reads the status word, the other codes the current address
	assign ans_data_w = (op_code == bcu_pkg::OP_STATUS_BOUT) ? status_w : cur_reg;
	assign dir_hit_w = dev_reply_i | dev_reject_i | (wait_cnt_reg == 9'(bcu_pkg::DEV_WAIT_CYCLES - 1));
	assign cur_inc_w = cur_reg + bcu_pkg::WORD_ONE;
	assign out_dir_w = ~buf_in_reg;
	always_comb begin
		status_w = bcu_pkg::WORD_ZERO;
		status_w[bcu_pkg::ST_READY] = 1'b1;
		status_w[bcu_pkg::ST_BUSY] = eng_busy_w;
		status_w[bcu_pkg::ST_IRQ] = irq_pend_reg;
		status_w[bcu_pkg::ST_EOO] = eoo_reg;
		status_w[bcu_pkg::ST_PFAULT] = pf_reg;
		status_w[bcu_pkg::ST_DREJ] = last_rej_reg;
		status_w[bcu_pkg::ST_DREP] = last_rep_reg;
	end
	// ****************
	// host answer sequencer
	// ****************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hst_reg <= bcu_pkg::H_IDLE;
			host_reply_reg <= 1'b0;
			host_reject_reg <= 1'b0;
			host_data_reg <= bcu_pkg::WORD_ZERO;
		end else if (ce_i) begin
			case (hst_reg)
				bcu_pkg::H_IDLE: begin
					if (new_req_w) begin
						if (rej_now_w) begin
							host_reject_reg <= 1'b1;
							hst_reg <= bcu_pkg::H_ANS;
						end else if (is_direct_w) begin
							hst_reg <= bcu_pkg::H_WAIT;
						end else begin
							host_reply_reg <= 1'b1;
							host_data_reg <= ans_data_w;
							hst_reg <= bcu_pkg::H_ANS;
						end
					end
				end
				bcu_pkg::H_WAIT: begin
					if (dir_hit_w) begin
						host_reply_reg <= dev_reply_i;
						host_reject_reg <= ~dev_reply_i;
						host_data_reg <= dev_rdata_i;
						hst_reg <= bcu_pkg::H_ANS;
					end
				end
				bcu_pkg::H_ANS: begin
					if (!host_req_i) begin
						host_reply_reg <= 1'b0;
						host_reject_reg <= 1'b0;
						hst_reg <= bcu_pkg::H_IDLE;
					end
				end
				default: begin
					hst_reg <= bcu_pkg::H_IDLE;
				end
			endcase
		end
	end
	// ****************
	// interrupt, protect and status flags
	// ****************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_reg <= 1'b0;
			irq_pend_reg <= 1'b0;
			eoo_reg <= 1'b0;
			pf_reg <= 1'b0;
			buf_prot_reg <= 1'b0;
		end else if (ce_i) begin
			if (do_func_w && host_data_i[bcu_pkg::TGT_BIT]) begin
				irq_en_reg <= host_data_i[bcu_pkg::SEL_BIT];
			end
			// set wins over the clear of the same cycle
			if (done_pulse_reg && irq_en_reg) begin
				irq_pend_reg <= 1'b1;
			end else if (do_func_w && host_data_i[bcu_pkg::TGT_BIT]) begin
				irq_pend_reg <= 1'b0;
			end
			if (done_pulse_reg) begin
				eoo_reg <= 1'b1;
			end else if (go_buffer_w) begin
				eoo_reg <= 1'b0;
			end
			if ((new_req_w && host_pfault_i) || fault_pulse_reg) begin
				pf_reg <= 1'b1;
			end else if (go_buffer_w) begin
				pf_reg <= 1'b0;
			end
			if (go_buffer_w) begin
				buf_prot_reg <= host_protect_i;
			end else if (!buf_active_reg) begin
				buf_prot_reg <= 1'b0;
			end
		end
	end
	// ****************
	// transfer engine: direct word and buffered block
	// ****************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			est_reg <= bcu_pkg::E_IDLE;
			buf_active_reg <= 1'b0;
			buf_in_reg <= 1'b0;
			cur_reg <= bcu_pkg::WORD_ZERO;
			end_reg <= bcu_pkg::WORD_ZERO;
			dev_addr_reg <= bcu_pkg::WORD_ZERO;
			dev_wdata_reg <= bcu_pkg::WORD_ZERO;
			dev_rd_reg <= 1'b0;
			dev_wr_reg <= 1'b0;
			dev_wzero_reg <= 1'b0;
			mem_req_reg <= 1'b0;
			mem_we_reg <= 1'b0;
			mem_addr_reg <= bcu_pkg::WORD_ZERO;
			mem_wdata_reg <= bcu_pkg::WORD_ZERO;
			wait_cnt_reg <= 9'h000;
			last_rep_reg <= 1'b0;
			last_rej_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
			fault_pulse_reg <= 1'b0;
		end else if (ce_i) begin
			dev_wzero_reg <= 1'b1;
			done_pulse_reg <= 1'b0;
			fault_pulse_reg <= 1'b0;
			if (do_term_w) begin
				// abort whatever word is in flight; the address stays as it was
				est_reg <= bcu_pkg::E_IDLE;
				buf_active_reg <= 1'b0;
				dev_rd_reg <= 1'b0;
				dev_wr_reg <= 1'b0;
				mem_req_reg <= 1'b0;
			end else begin
				case (est_reg)
					bcu_pkg::E_IDLE: begin
						if (go_direct_w) begin
							dev_addr_reg <= host_addr_i;
							dev_wdata_reg <= host_data_i;
							dev_rd_reg <= host_read_i;
							dev_wr_reg <= ~host_read_i;
							wait_cnt_reg <= 9'h000;
							est_reg <= bcu_pkg::E_DIR;
						end else if (go_buffer_w) begin
							dev_addr_reg <= host_addr_i;
							buf_in_reg <= (op_code == bcu_pkg::OP_ADDR_BIN);
							buf_active_reg <= 1'b1;
							cur_reg <= host_data_i + bcu_pkg::WORD_ONE;
							mem_addr_reg <= host_data_i;
							mem_we_reg <= 1'b0;
							mem_req_reg <= 1'b1;
							est_reg <= bcu_pkg::E_PTR;
						end
					end
					bcu_pkg::E_DIR: begin
						wait_cnt_reg <= wait_cnt_reg + 9'h001;
						if (dir_hit_w) begin
							dev_rd_reg <= 1'b0;
							dev_wr_reg <= 1'b0;
							last_rep_reg <= dev_reply_i;
							last_rej_reg <= ~dev_reply_i;
							est_reg <= bcu_pkg::E_IDLE;
						end
					end
					bcu_pkg::E_PTR: begin
						if (mem_ack_i) begin
							mem_req_reg <= 1'b0;
							end_reg <= mem_rdata_i;
							if (mem_fault_i) begin
								fault_pulse_reg <= 1'b1;
								buf_active_reg <= 1'b0;
								est_reg <= bcu_pkg::E_IDLE;
							end else if (mem_rdata_i == cur_reg) begin
								// empty block ends at once
								done_pulse_reg <= 1'b1;
								buf_active_reg <= 1'b0;
								est_reg <= bcu_pkg::E_IDLE;
							end else if (out_dir_w) begin
								mem_addr_reg <= cur_reg;
								mem_req_reg <= 1'b1;
								est_reg <= bcu_pkg::E_MEM;
							end else begin
								dev_rd_reg <= 1'b1;
								est_reg <= bcu_pkg::E_DEV;
							end
						end
					end
					bcu_pkg::E_MEM: begin
						if (mem_ack_i) begin
							mem_req_reg <= 1'b0;
							mem_we_reg <= 1'b0;
							if (mem_fault_i) begin
								fault_pulse_reg <= 1'b1;
								buf_active_reg <= 1'b0;
								est_reg <= bcu_pkg::E_IDLE;
							end else if (out_dir_w) begin
								dev_wdata_reg <= mem_rdata_i;
								dev_wr_reg <= 1'b1;
								est_reg <= bcu_pkg::E_DEV;
							end else begin
								cur_reg <= cur_inc_w;
								if (cur_inc_w == end_reg) begin
									done_pulse_reg <= 1'b1;
									buf_active_reg <= 1'b0;
									est_reg <= bcu_pkg::E_IDLE;
								end else begin
									dev_rd_reg <= 1'b1;
									est_reg <= bcu_pkg::E_DEV;
								end
							end
						end
					end
					bcu_pkg::E_DEV: begin
						if (dev_reply_i) begin
							dev_rd_reg <= 1'b0;
							dev_wr_reg <= 1'b0;
							last_rep_reg <= 1'b1;
							last_rej_reg <= 1'b0;
							if (buf_in_reg) begin
								mem_addr_reg <= cur_reg;
								mem_wdata_reg <= dev_rdata_i;
								mem_we_reg <= 1'b1;
								mem_req_reg <= 1'b1;
								est_reg <= bcu_pkg::E_MEM;
							end else begin
								cur_reg <= cur_inc_w;
								if (cur_inc_w == end_reg) begin
									done_pulse_reg <= 1'b1;
									buf_active_reg <= 1'b0;
									est_reg <= bcu_pkg::E_IDLE;
								end else begin
									mem_addr_reg <= cur_inc_w;
									mem_req_reg <= 1'b1;
									est_reg <= bcu_pkg::E_MEM;
								end
							end
						end else if (dev_reject_i) begin
							// the same word is offered again, storage is not re-read
							dev_rd_reg <= 1'b0;
							dev_wr_reg <= 1'b0;
							last_rep_reg <= 1'b0;
							last_rej_reg <= 1'b1;
							est_reg <= bcu_pkg::E_GAP;
						end
					end
					bcu_pkg::E_GAP: begin
						dev_rd_reg <= buf_in_reg;
						dev_wr_reg <= out_dir_w;
						est_reg <= bcu_pkg::E_DEV;
					end
					default: begin
						est_reg <= bcu_pkg::E_IDLE;
					end
				endcase
			end
		end
	end
	// ****************
	// register slave and outputs
	// ****************
	bcu_wb_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.status_i(status_w),
		.cur_addr_i(cur_reg),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.base_code_o(base_code)
	);
	assign host_reply_o = host_reply_reg;
	assign host_reject_o = host_reject_reg;
	assign host_data_o = host_data_reg;
	assign host_irq_o = irq_pend_reg;
	assign dev_addr_o = dev_addr_reg;
	assign dev_wdata_o = dev_wdata_reg;
	assign dev_rd_o = dev_rd_reg;
	assign dev_wr_o = dev_wr_reg;
	assign dev_wzero_o = dev_wzero_reg;
	assign mem_req_o = mem_req_reg;
	assign mem_we_o = mem_we_reg;
	assign mem_addr_o = mem_addr_reg;
	assign mem_wdata_o = mem_wdata_reg;
endmodule

/* verification/bcu_channel_properties.sv */
// checker: port-level properties of the buffered channel command unit
`timescale 1ns/1ps
module bcu_channel_props #(
	parameter logic [3:0] BASE = 4'h2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic host_req_i,
	input wire logic host_read_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [15:0] host_data_i,
	input wire logic host_pfault_i,
	input wire logic host_reply_o,
	input wire logic host_reject_o,
	input wire logic [15:0] host_data_o,
	input wire logic host_irq_o,
	input wire logic [15:0] dev_wdata_o,
	input wire logic dev_rd_o,
	input wire logic dev_wr_o,
	input wire logic dev_reply_i,
	input wire logic dev_reject_i,
	input wire logic dev_wzero_o,
	input wire logic mem_req_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	// ****************
	// instruction decode
	// ****************
	logic [3:0] code;
	logic direct_q, mine, ans, strobe, func_q;
	assign code = host_addr_i[14:11];
	assign direct_q = host_addr_i[15] || code == BASE;
	// wraps below the base, so one compare covers all four codes
	assign mine = direct_q || code - BASE < 4'h4;
	assign ans = host_reply_o || host_reject_o;
	assign strobe = dev_rd_o || dev_wr_o;
	assign func_q = !host_addr_i[15] && code == BASE + 4'h1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	answer_time_a: assert property (host_req_i && mine && !ans |-> ##[1:400] ans)
		else $error("no answer in time");
	one_answer_a: assert property (!(host_reply_o && host_reject_o))
		else $error("reply and reject together");
	fault_reject_a: assert property ($rose(host_req_i) && host_pfault_i && mine |-> ##[1:2] host_reject_o)
		else $error("fault not rejected");
	dev_refusal_a: assert property (host_req_i && direct_q && dev_reject_i && strobe |-> ##[1:2] host_reject_o)
		else $error("device refusal not passed on");
	irq_clear_a: assert property ($rose(host_reply_o) && func_q && !host_read_i && host_data_i[0] |-> !host_irq_o)
		else $error("interrupt not cleared");
	status_ready_a: assert property ($rose(host_reply_o) && host_read_i && !host_addr_i[15]
		&& code == BASE + 4'h2 |-> host_data_o[0])
		else $error("ready bit missing");
	zero_select_a: assert property (!$past(rst_i) |-> dev_wzero_o)
		else $error("select zero indication low");
	mem_hold_a: assert property (mem_req_o && !mem_ack_i && !host_req_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("storage request dropped");
	strobe_hold_a: assert property (dev_wr_o && !dev_reply_i && !dev_reject_i && !host_req_i
		|=> dev_wr_o && $stable(dev_wdata_o))
		else $error("write strobe dropped");
	wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bad bus acknowledge");
	cover property ($rose(host_irq_o));
	cover property (host_reject_o && host_req_i);
	cover property (mem_req_o && mem_ack_i);
endmodule

bind bcu_channel bcu_channel_props u_props (.*);

/* verification/bcu_far_model.sv */
// partner: device controller and storage behind the channel
`timescale 1ns/1ps
module bcu_far_model (
	input wire logic clk_i,
	input wire logic dev_rd_i,
	input wire logic dev_wr_i,
	input wire logic [15:0] dev_wdata_i,
	input wire logic [3:0] delay_i,
	input wire logic reject_i,
	output logic [15:0] dev_rdata_o,
	output logic dev_reply_o,
	output logic dev_reject_o,
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic [15:0] mem_wdata_i,
	output logic [15:0] mem_rdata_o,
	output logic mem_ack_o
);
	logic [15:0] mem [0:63];
	logic [15:0] last_w, n_words;
	logic [3:0] cnt;
	logic [1:0] mcnt;
	logic held;
	initial begin
		{dev_rdata_o, mem_rdata_o, last_w, n_words} = 64'h0000_0000_0000_0000;
		{dev_reply_o, dev_reject_o, mem_ack_o, held, cnt, mcnt} = 10'h000;
	end
	always @(posedge clk_i) begin
		dev_reply_o <= 1'b0;
		dev_reject_o <= 1'b0;
		mem_ack_o <= 1'b0;
		// released lines keep moving so a stale word never passes for data
		dev_rdata_o <= ~dev_rdata_o;
		mem_rdata_o <= ~mem_rdata_o;
		if (!(dev_rd_i || dev_wr_i)) begin
			cnt <= 4'h0;
			held <= 1'b0;
		end else if (!held) begin
			cnt <= cnt + 4'h1;
			if (cnt == delay_i) begin
				held <= 1'b1;
				if (reject_i) begin
					dev_reject_o <= 1'b1;
				end else begin
					dev_reply_o <= 1'b1;
					dev_rdata_o <= 16'h5A00 + n_words;
					n_words <= n_words + 16'h0001;
					if (dev_wr_i) begin
						last_w <= dev_wdata_i;
					end
				end
			end
		end
		if (!mem_req_i || mem_ack_o) begin
			mcnt <= 2'h0;
		end else if (mcnt == 2'h2) begin
			mem_ack_o <= 1'b1;
			if (mem_we_i) begin
				mem[mem_addr_i[5:0]] <= mem_wdata_i;
			end else begin
				mem_rdata_o <= mem[mem_addr_i[5:0]];
			end
		end else begin
			mcnt <= mcnt + 2'h1;
		end
	end
endmodule

/* verification/bcu_channel_tb_top.sv */
// testbench: host, register bus and far side around the channel
`timescale 1ns/1ps
module bcu_channel_tb_top;
	logic clk_i, rst_i, ce_i, host_req_i, host_read_i, host_protect_i, host_pfault_i, host_reply_o, host_reject_o;
	logic host_irq_o, dev_rd_o, dev_wr_o, dev_reply_i, dev_reject_i, dev_wzero_o, mem_req_o, mem_we_o, mem_ack_i;
	logic mem_fault_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rep, rej, rej_mode;
	logic [15:0] host_addr_i, host_data_i, host_data_o, dev_addr_o, dev_wdata_o, dev_rdata_i, mem_addr_o;
	logic [15:0] mem_wdata_o, mem_rdata_i, rdat, hr;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, wdat;
	int checks = 0;
	int n_mismatch = 0;
	int cyc = 0;
	localparam logic [15:0] RP = 16'h0001;
	localparam logic [15:0] RJ = 16'h0002;
	assign hr = {14'h0000, rej, rep};
	bcu_channel dut (.*);
	bcu_far_model far (.clk_i, .dev_rd_i(dev_rd_o), .dev_wr_i(dev_wr_o), .dev_wdata_i(dev_wdata_o), .delay_i(4'h8),
		.reject_i(rej_mode), .dev_rdata_o(dev_rdata_i), .dev_reply_o(dev_reply_i), .dev_reject_o(dev_reject_i),
		.mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
		.mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
	// ****************
	// shared tasks
	// ****************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic host(input logic rd, input logic [15:0] q, input logic [15:0] a, input logic prot, input logic pf);
		int n;
		n = 0;
		host_req_i <= 1'b1;
		host_read_i <= rd;
		host_addr_i <= q;
		host_data_i <= a;
		host_protect_i <= prot;
		host_pfault_i <= pf;
		// give up like the host would, with neither answer seen
		do begin
			@(posedge clk_i);
			n++;
		end while (!(host_reply_o || host_reject_o) && n < 500);
		rep = host_reply_o;
		rej = host_reject_o;
		rdat = host_data_o;
		host_req_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (!wb_ack_o);
		wdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset_regs();
		wb(1'b0, 4'h8, 32'h0000_0000);
		check("base code", 16'h0002, wdat[15:0]);
		wb(1'b1, 4'h8, 32'h0000_FFF5);
		wb(1'b0, 4'h8, 32'h0000_0000);
		check("base write", 16'h0005, wdat[15:0]);
		wb(1'b1, 4'h8, 32'h0000_0002);
		wb(1'b0, 4'hC, 32'h0000_0000);
		check("unmapped", 16'h0000, wdat[15:0]);
		host(1'b1, 16'h2000, 16'h0000, 1'b0, 1'b0);
		check("status answer", RP, hr);
		check("status word", 16'h0001, rdat);
		$display("test reset_regs done");
	endtask
	task automatic t_direct();
		host(1'b0, 16'h1005, 16'h1234, 1'b0, 1'b0);
		check("direct answer", RP, hr);
		check("device word", 16'h1234, far.last_w);
		check("device address", 16'h1005, dev_addr_o);
		host(1'b1, 16'h8005, 16'h0000, 1'b0, 1'b0);
		check("continue input", 16'h5A01, rdat);
		rej_mode <= 1'b1;
		host(1'b0, 16'h1005, 16'h0001, 1'b0, 1'b0);
		check("device refusal", RJ, hr);
		rej_mode <= 1'b0;
		host(1'b1, 16'h2000, 16'h0000, 1'b0, 1'b0);
		check("refusal status", 16'h0101, rdat);
		host(1'b1, 16'h2000, 16'h0000, 1'b0, 1'b1);
		check("fault answer", RJ, hr);
		$display("test direct done");
	endtask
	task automatic t_buffer_out();
		far.mem[16] = 16'h0013;
		far.mem[17] = 16'hC001;
		far.mem[18] = 16'hC002;
		host(1'b0, 16'h1800, 16'h8001, 1'b0, 1'b0);
		check("enable answer", RP, hr);
		host(1'b0, 16'h2000, 16'h0010, 1'b0, 1'b0);
		check("start answer", RP, hr);
		host(1'b0, 16'h1005, 16'h0000, 1'b0, 1'b0);
		check("busy direct", RJ, hr);
		host(1'b0, 16'h2800, 16'h0010, 1'b0, 1'b0);
		check("busy start", RJ, hr);
		repeat (300) if (!host_irq_o) @(posedge clk_i);
		check("end interrupt", 16'h0001, {15'h0000, host_irq_o});
		check("last word", 16'hC002, far.last_w);
		check("words moved", 16'h0004, far.n_words);
		host(1'b1, 16'h2000, 16'h0000, 1'b0, 1'b0);
		check("done status", 16'h0215, rdat);
		host(1'b1, 16'h2800, 16'h0000, 1'b0, 1'b0);
		check("end address", 16'h0013, rdat);
		host(1'b0, 16'h1800, 16'h0001, 1'b0, 1'b0);
		check("cleared irq", 16'h0000, {15'h0000, host_irq_o});
		$display("test buffer_out done");
	endtask
	task automatic t_protected();
		far.mem[32] = 16'h0023;
		rej_mode <= 1'b1;
		host(1'b0, 16'h2800, 16'h0020, 1'b1, 1'b0);
		check("protected start", RP, hr);
		repeat (20) @(posedge clk_i);
		host(1'b1, 16'h2000, 16'h0000, 1'b0, 1'b0);
		check("open status", RJ, hr);
		host(1'b0, 16'h1800, 16'h8001, 1'b0, 1'b0);
		check("open function", RJ, hr);
		host(1'b1, 16'h2800, 16'h0000, 1'b1, 1'b0);
		check("current address", 16'h0021, rdat);
		host(1'b1, 16'h1800, 16'h0000, 1'b1, 1'b0);
		check("stop address", 16'h0021, rdat);
		rej_mode <= 1'b0;
		host(1'b1, 16'h2000, 16'h0000, 1'b0, 1'b0);
		check("busy after stop", 16'h0000, rdat & 16'h0002);
		far.mem[48] = 16'h0032;
		host(1'b0, 16'h2800, 16'h0030, 1'b0, 1'b0);
		repeat (60) @(posedge clk_i);
		check("stored word", 16'h5A04, far.mem[49]);
		$display("test protected done");
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		{rst_i, ce_i, host_req_i, host_read_i, host_protect_i, host_pfault_i} = 6'h30;
		{mem_fault_i, wb_cyc_i, wb_stb_i, wb_we_i, rej_mode} = 5'h00;
		{host_addr_i, host_data_i, wb_adr_i, wb_sel_i, wb_dat_i} = 72'h00_0000_0000_F000_0000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset_regs();
		t_direct();
		t_buffer_out();
		t_protected();
		report_and_stop();
	end
endmodule
